// File: design/ssc_top.sv
// Sync code registers, dark-level fault flags and the code word emitter.
// Assumes an APB master on clk, a marker requester and a channel
// serialiser on the same clock, and a calibration engine pulsing faults.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps

`include "ssc_defines.svh"

module ssc_top import ssc_pkg::*; #(
  parameter int FIFO_DEPTH = `SSC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SSC_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Marker requests
  input wire logic mark_valid,
  input wire ssc_kind_t mark_kind,
  output logic mark_ready,
  // Calibration engine
  input wire logic [`SSC_FAULT_CH-1:0] fault_set,
  input wire logic fault_clear,
  // Data channel
  input wire logic chan_ready,
  output logic chan_valid,
  output ssc_code_t chan_word,
  output logic chan_is_marker
);

  // ==========================================================
  // Queue between requester and emitter
  ssc_stream_if #(.W($bits(ssc_kind_t))) push_s ();
  ssc_stream_if #(.W($bits(ssc_kind_t))) pop_s ();

  // Marker queue instance
  ssc_fifo #(
    .W($bits(ssc_kind_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_s(push_s),
    .out_s(pop_s)
  );

  assign push_s.valid = mark_valid;
  assign push_s.data = mark_kind;
  // Ready comes straight from a flop inside the queue
  assign mark_ready = push_s.ready;

  // ==========================================================
  // Register state
  logic [`SSC_FRAME_LSB_W-1:0] frame_code_reg; // Writable low frame bits
  ssc_code_t code_reg [`SSC_CODE_CNT]; // Dark, valid, check, training
  logic [`SSC_FAULT_CH-1:0] fault_reg; // One flag per channel
  logic pready_reg; // High in the first access cycle
  logic pslverr_reg; // Unmapped or misaligned
  logic [31:0] prdata_reg; // Read data captured at setup

  // Index and reset tables of the four full code words
  localparam logic [`SSC_IDX_W-1:0] CODE_IDX [`SSC_CODE_CNT] = '{
    `SSC_IDX_DARK, `SSC_IDX_VALID, `SSC_IDX_CHECK, `SSC_IDX_TRAIN};
  localparam ssc_code_t CODE_RST [`SSC_CODE_CNT] = '{
    `SSC_RST_DARK, `SSC_RST_VALID, `SSC_RST_CHECK, `SSC_RST_TRAIN};

  // ==========================================================
  // APB decode
  logic [`SSC_IDX_W-1:0] idx; // Word index
  logic setup; // Setup cycle of a transfer
  logic wr_fire; // Write takes effect here
  logic aligned; // Low address bits clear
  logic hit; // Index is mapped
  logic [15:0] rd_word; // Register value before widening

  assign idx = paddr[`SSC_APB_AW-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel & ~penable;
  assign wr_fire = psel & penable & pready_reg & pwrite & aligned & hit;

  // Read mux and hit detection
  always_comb begin
    rd_word = 16'h0000;
    hit = 1'b1;
    if (idx == `SSC_IDX_FRAME) begin
      // Fixed upper bits are not stored, they read as zero
      rd_word = {{(16-`SSC_FRAME_LSB_W){1'b0}}, frame_code_reg};
    end else if (idx == `SSC_IDX_DARK) begin
      rd_word = {6'h00, code_reg[`SSC_CODE_DARK]};
    end else if (idx == `SSC_IDX_VALID) begin
      rd_word = {6'h00, code_reg[`SSC_CODE_VALID]};
    end else if (idx == `SSC_IDX_CHECK) begin
      rd_word = {6'h00, code_reg[`SSC_CODE_CHECK]};
    end else if (idx == `SSC_IDX_TRAIN) begin
      rd_word = {6'h00, code_reg[`SSC_CODE_TRAIN]};
    end else if (idx == `SSC_IDX_FAULT0) begin
      rd_word = fault_reg[15:0]; // RULE7
    end else if (idx == `SSC_IDX_FAULT1) begin
      rd_word = fault_reg[31:16];
    end else if (idx == `SSC_IDX_FAULT2) begin
      rd_word = fault_reg[47:32];
    end else if (idx == `SSC_IDX_FAULT3) begin
      rd_word = fault_reg[63:48];
    end else if (idx == `SSC_IDX_SPARE_A) begin
      // Spare words show their reset pattern, writes are dropped
      rd_word = `SSC_RST_SPARE_A;
    end else if (idx == `SSC_IDX_SPARE_B) begin
      rd_word = `SSC_RST_SPARE_B;
    end else begin
      hit = 1'b0;
    end
  end

  // Answer: zero wait states, ready raised for the first access cycle only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= ~(aligned & hit);
        // Data captured in setup; upper half always reads zero
        prdata_reg <= (!pwrite && aligned && hit) ? {16'h0000, rd_word} : 32'h0000_0000;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // ==========================================================
  // Code registers
  // Frame marker keeps only its low bits; the top three are built
  // by the emitter, so no write can reach them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_code_reg <= `SSC_RST_FRAME;
    end else if (wr_fire && idx == `SSC_IDX_FRAME && pstrb[0]) begin
      frame_code_reg <= pwdata[`SSC_FRAME_LSB_W-1:0]; // RULE1
    end
  end

  // Dark, valid, check and training codes, lane by lane
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `SSC_CODE_CNT; i++) begin
        code_reg[i] <= CODE_RST[i]; // RULE3 RULE4 RULE5 RULE8
      end
    end else begin
      for (int i = 0; i < `SSC_CODE_CNT; i++) begin
        if (wr_fire && idx == CODE_IDX[i]) begin
          if (pstrb[0]) code_reg[i][7:0] <= pwdata[7:0];
          if (pstrb[1]) code_reg[i][9:8] <= pwdata[9:8];
        end
      end
    end
  end

  // ==========================================================
  // Dark-level fault flags
  // A set that lands with a clear wins, so no fault is lost
  // when a new calibration run starts in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= fault_set | (fault_reg & ~{`SSC_FAULT_CH{fault_clear}}); // RULE6
    end
  end

  // ==========================================================
  // Code word emitter
  logic advance; // Output stage free or being taken
  ssc_kind_t head_kind; // Kind at the head of the queue
  ssc_code_t mark_word; // Word built from the head kind
  logic chan_valid_reg; // Word on the channel
  ssc_code_t chan_word_reg; // Word held until taken
  logic chan_is_marker_reg; // Word came from the queue

  assign advance = ~chan_valid_reg | chan_ready;
  assign pop_s.ready = advance;
  assign head_kind = ssc_kind_t'(pop_s.data);

  // Build the marker word from current register values
  always_comb begin
    mark_word = code_reg[`SSC_CODE_TRAIN];
    case (head_kind)
      KIND_FRAME_START: begin
        mark_word = {1'b1, 1'b1, 1'b0, frame_code_reg}; // RULE2
      end
      KIND_FRAME_END: begin
        mark_word = {1'b1, 1'b0, 1'b1, frame_code_reg}; // RULE2
      end
      KIND_DARK: begin
        mark_word = code_reg[`SSC_CODE_DARK]; // RULE3
      end
      KIND_VALID: begin
        mark_word = code_reg[`SSC_CODE_VALID]; // RULE4
      end
      KIND_CHECK: begin
        mark_word = code_reg[`SSC_CODE_CHECK]; // RULE5
      end
      default: begin
        mark_word = code_reg[`SSC_CODE_TRAIN];
      end
    endcase
  end

  // The word is latched once and held while the channel stalls, so
  // a register write never alters a word already on its way out.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_valid_reg <= 1'b0;
      chan_word_reg <= '0;
      chan_is_marker_reg <= 1'b0;
    end else if (advance) begin // RULE9
      chan_valid_reg <= 1'b1;
      if (pop_s.valid) begin
        chan_word_reg <= mark_word;
        chan_is_marker_reg <= 1'b1;
      end else begin
        // Nothing queued: keep the receiver aligned
        chan_word_reg <= code_reg[`SSC_CODE_TRAIN]; // RULE8
        chan_is_marker_reg <= 1'b0;
      end
    end
  end

  assign chan_valid = chan_valid_reg;
  assign chan_word = chan_word_reg;
  assign chan_is_marker = chan_is_marker_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Steps of a bus transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready_reg;
  endsequence

  a_apb_zero_wait: assert property (s_setup |=> pready_reg) // RULE7
    else $error("ready missing in first access cycle");

  a_frame_low_write: assert property ( // RULE1
    (wr_fire && idx == `SSC_IDX_FRAME && pstrb[0])
      |=> frame_code_reg == $past(pwdata[`SSC_FRAME_LSB_W-1:0]))
    else $error("frame low bits not written");

  a_frame_mark_bits: assert property ( // RULE2
    (advance && pop_s.valid && head_kind == KIND_FRAME_END)
      |=> chan_word_reg[`SSC_BIT_MARK:`SSC_BIT_END] == 3'h5 && chan_is_marker_reg)
    else $error("frame end marker bits wrong");

  a_dark_tag_out: assert property ( // RULE3
    (advance && pop_s.valid && head_kind == KIND_DARK)
      |=> chan_word_reg == $past(code_reg[`SSC_CODE_DARK]))
    else $error("dark tag word wrong");

  a_valid_tag_out: assert property ( // RULE4
    (advance && pop_s.valid && head_kind == KIND_VALID)
      |=> chan_word_reg == $past(code_reg[`SSC_CODE_VALID]))
    else $error("valid tag word wrong");

  a_check_tag_out: assert property ( // RULE5
    (advance && pop_s.valid && head_kind == KIND_CHECK)
      |=> chan_word_reg == $past(code_reg[`SSC_CODE_CHECK]))
    else $error("check tag word wrong");

  a_fault_set_wins: assert property ( // RULE6
    (fault_set != '0) |=> (fault_reg & $past(fault_set)) == $past(fault_set))
    else $error("fault flag lost");

  a_fault_read_path: assert property ( // RULE7
    (s_setup ##0 (!pwrite && idx == `SSC_IDX_FAULT3 && aligned))
      ##1 s_access |-> prdata_reg[15:0] == $past(fault_reg[63:48]))
    else $error("fault word read wrong");

  a_training_idle: assert property ( // RULE8
    (advance && !pop_s.valid)
      |=> chan_word_reg == $past(code_reg[`SSC_CODE_TRAIN]) && !chan_is_marker_reg)
    else $error("training word missing while idle");

  a_word_held_stall: assert property ( // RULE9
    (chan_valid_reg && !chan_ready) |=> $stable(chan_word_reg) && $stable(chan_is_marker_reg))
    else $error("channel word changed during stall");

  // ==========================================================
  // Further guards: lanes, refusals, flags and the channel

  // Emitter takes a queued start marker
  sequence s_take_start;
    advance && pop_s.valid && head_kind == KIND_FRAME_START;
  endsequence

  a_frame_start_bits: assert property ( // RULE2
    s_take_start |=> chan_word_reg[`SSC_BIT_MARK:`SSC_BIT_END] == 3'h6 && chan_is_marker_reg)
    else $error("frame start marker bits wrong");

  // Both lanes written lands the whole code
  a_dark_code_write: assert property ( // RULE3
    (wr_fire && idx == `SSC_IDX_DARK && pstrb[1:0] == 2'h3)
      |=> code_reg[`SSC_CODE_DARK] == $past(pwdata[`SSC_CODE_W-1:0]))
    else $error("dark tag write lost");

  a_train_code_write: assert property ( // RULE8
    (wr_fire && idx == `SSC_IDX_TRAIN && pstrb[1:0] == 2'h3)
      |=> code_reg[`SSC_CODE_TRAIN] == $past(pwdata[`SSC_CODE_W-1:0]))
    else $error("training word write lost");

  // Without its lane the frame marker keeps its bits
  a_frame_lane_off: assert property ( // RULE1
    (wr_fire && idx == `SSC_IDX_FRAME && !pstrb[0]) |=> $stable(frame_code_reg))
    else $error("frame bits written without lane");

  // Refused writes leave every code alone
  a_refuse_keeps_codes: assert property ( // RULE1
    (psel && penable && pready_reg && pwrite && !(aligned && hit))
      |=> $stable(frame_code_reg) && $stable(code_reg[`SSC_CODE_DARK]) && $stable(code_reg[`SSC_CODE_VALID])
        && $stable(code_reg[`SSC_CODE_CHECK]) && $stable(code_reg[`SSC_CODE_TRAIN]))
    else $error("refused write changed a code");

  a_bad_access_error: assert property ( // RULE7
    (s_setup ##0 !(aligned && hit)) |=> pready_reg && pslverr_reg)
    else $error("refused access not flagged");

  a_ready_one_cycle: assert property (pready_reg |=> !pready_reg) // RULE7
    else $error("ready held past one cycle");

  // A clear drops every flag that is not set again at once
  a_clear_drops_flags: assert property ( // RULE6
    fault_clear |=> (fault_reg & ~$past(fault_set)) == '0)
    else $error("fault flag survived clear");

  a_chan_never_rests: assert property (chan_valid_reg |=> chan_valid_reg) // RULE8
    else $error("channel went idle");

endmodule : ssc_top

// File: inc/ssc_defines.svh
// Constants of the sync code and dark-level fault block: offsets, resets, fields.
// Assumes inclusion by bare name from the package and the design files.
// Contract
// [RULE1] Only low seven frame marker bits writable
// [RULE2] Marker bits: top marker, start, end
// [RULE3] Writable dark pixel tag, reset 0x015
// [RULE4] Writable valid pixel tag, reset 0x035
// [RULE5] Writable check value tag, reset 0x059
// [RULE6] Channel fault flag set on too few samples
// [RULE7] Four read-only fault words, sixteen channels each
// [RULE8] Training word sent while idle, reset 0x3a6
// [RULE9] New code applies from next word only
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// ==========================================================
// Code word layout
`define SSC_CODE_W 10
`define SSC_FRAME_LSB_W 7
`define SSC_BIT_MARK 9
`define SSC_BIT_START 8
`define SSC_BIT_END 7

// ==========================================================
// Register indices, byte address is four times the index
`define SSC_APB_AW 8
`define SSC_IDX_W 6
`define SSC_IDX_FRAME 6'h03
`define SSC_IDX_DARK 6'h04
`define SSC_IDX_VALID 6'h05
`define SSC_IDX_CHECK 6'h06
`define SSC_IDX_TRAIN 6'h07
`define SSC_IDX_FAULT0 6'h08
`define SSC_IDX_FAULT1 6'h09
`define SSC_IDX_FAULT2 6'h0a
`define SSC_IDX_FAULT3 6'h0b
`define SSC_IDX_SPARE_A 6'h0c
`define SSC_IDX_SPARE_B 6'h0d

// ==========================================================
// Reset values
`define SSC_RST_FRAME 7'h2a
`define SSC_RST_DARK 10'h015
`define SSC_RST_VALID 10'h035
`define SSC_RST_CHECK 10'h059
`define SSC_RST_TRAIN 10'h3a6
`define SSC_RST_SPARE_A 16'h0000
`define SSC_RST_SPARE_B 16'hffff

// ==========================================================
// Sizes
`define SSC_FAULT_CH 64
`define SSC_FIFO_DEPTH 8
`define SSC_CODE_CNT 4
`define SSC_CODE_DARK 0
`define SSC_CODE_VALID 1
`define SSC_CODE_CHECK 2
`define SSC_CODE_TRAIN 3

`endif

// File: inc/ssc_pkg.sv
// Types shared by the sync code block and its marker queue.
// Assumes ssc_defines.svh sits on the include path.
`include "ssc_defines.svh"

package ssc_pkg;

  // ==========================================================
  // Kinds of marker a requester can queue
  typedef enum logic [2:0] {
    KIND_FRAME_START,
    KIND_FRAME_END,
    KIND_DARK,
    KIND_VALID,
    KIND_CHECK
  } ssc_kind_t;

  // One code word on a data channel
  typedef logic [`SSC_CODE_W-1:0] ssc_code_t;

endpackage : ssc_pkg

// File: inc/ssc_stream_if.sv
// Valid/ready stream between the sync code block and its marker queue.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps

interface ssc_stream_if #(parameter int W = 3) ();
  logic valid; // Data offered
  logic ready; // Data accepted when valid too
  logic [W-1:0] data; // Payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ssc_stream_if

// File: design/ssc_fifo.sv
// Marker queue: DEPTH words in an array plus a registered head word.
// Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
`timescale 1ns/100ps

`include "ssc_defines.svh"

module ssc_fifo #(
  parameter int W = 3,
  parameter int DEPTH = `SSC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Filling side
  ssc_stream_if.snk in_s,
  // Draining side
  ssc_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers
  logic [W-1:0] mem [DEPTH]; // Array, no reset needed
  logic [AW-1:0] wr_ptr_reg; // Next slot to fill
  logic [AW-1:0] rd_ptr_reg; // Next slot to drain
  logic [AW:0] cnt_reg; // Words in the array
  logic [AW:0] cnt_next;
  logic in_ready_reg; // Registered so the top sees a flop
  logic head_valid_reg; // Head word present
  logic [W-1:0] head_reg; // Read data come out of this register
  logic push;
  logic load;

  assign push = in_s.valid & in_ready_reg;
  // Refill the head when it is empty or being taken
  assign load = (cnt_reg != '0) & (~head_valid_reg | out_s.ready);
  assign in_s.ready = in_ready_reg;
  assign out_s.valid = head_valid_reg;
  assign out_s.data = head_reg;

  // Count follows pushes and loads
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !load) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (load && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Array write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_s.data;
    end
  end

  // Pointers, count and ready; ready drops the cycle the array fills
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      in_ready_reg <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (load) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      cnt_reg <= cnt_next;
      in_ready_reg <= (cnt_next != (AW+1)'(DEPTH));
    end
  end

  // Head register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      head_valid_reg <= 1'b0;
      head_reg <= '0;
    end else if (load) begin
      head_valid_reg <= 1'b1;
      head_reg <= mem[rd_ptr_reg];
    end else if (out_s.ready) begin
      head_valid_reg <= 1'b0;
    end
  end

endmodule : ssc_fifo

// File: testbench/ssc_rx_model.sv
// Receiver model that decodes the code word channel of the sync code block.
// Assumes the design's clock; the bench commands stalls through stall.
`timescale 1ns/100ps

// ==========================================================
// Channel receiver
module ssc_rx_model import ssc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Channel from the design
  input wire logic chan_valid,
  input wire ssc_code_t chan_word,
  input wire logic chan_is_marker,
  output logic chan_ready,
  // Bench control and view
  input wire logic stall,
  output ssc_code_t last_train,
  output int gaps
);
  // Marker words in arrival order, drained by the bench
  ssc_code_t got[$];

  // Ready is registered so a stall always starts on a clean edge
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_ready <= 1'b0;
      last_train <= '0;
      gaps <= 0;
    end else begin
      chan_ready <= !stall;
      // The channel never rests once reset has gone
      if (chan_ready && chan_valid !== 1'b1) begin
        gaps <= gaps + 1;
      end
      if (chan_valid && chan_ready) begin
        if (chan_is_marker) begin
          got.push_back(chan_word);
        end else begin
          last_train <= chan_word;
        end
      end
    end
  end
endmodule : ssc_rx_model

// File: testbench/testbench.sv
// Self-checking bench of the sync code block: APB, markers, faults, channel.
// Assumes ssc_top and ssc_rx_model compiled before it.
`timescale 1ns/100ps

module testbench import ssc_pkg::*;;
  // Design inputs, all defined at time zero
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic mark_valid = 1'b0, fault_clear = 1'b0, stall = 1'b0;
  ssc_kind_t mark_kind = KIND_FRAME_START;
  logic [63:0] fault_set = 64'h0;
  // Design outputs
  logic [31:0] prdata;
  logic pready, pslverr, mark_ready, chan_ready, chan_valid, chan_is_marker;
  ssc_code_t chan_word, last_train;
  int gaps;
  // Bench state
  int err_total = 0, n_checks = 0, cyc = 0;
  integer seed = 32'hf7fb;
  logic [15:0] exp_reg [3:13];
  logic [63:0] exp_flt = 64'h0;
  logic [31:0] rd;
  logic er;
  ssc_code_t exp_q[$];

  // ==========================================================
  // Clock, design and receiver
  initial begin
    forever #5 clk = ~clk;
  end
  ssc_top #(.FIFO_DEPTH(8)) dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mark_valid(mark_valid), .mark_kind(mark_kind),
    .mark_ready(mark_ready), .fault_set(fault_set), .fault_clear(fault_clear),
    .chan_ready(chan_ready), .chan_valid(chan_valid), .chan_word(chan_word),
    .chan_is_marker(chan_is_marker));
  ssc_rx_model rx_u (.clk(clk), .arst_n(arst_n), .chan_valid(chan_valid), .chan_word(chan_word),
    .chan_is_marker(chan_is_marker), .chan_ready(chan_ready), .stall(stall),
    .last_train(last_train), .gaps(gaps));

  // ==========================================================
  // Checks and expectations
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Channel words compare at their own width
  task automatic chk_code(input ssc_code_t g, input ssc_code_t e);
    chk({22'h0, g}, {22'h0, e});
  endtask : chk_code

  // Register image after reset
  task automatic set_defaults();
    for (int i = 3; i <= 13; i++) exp_reg[i] = 16'h0000;
    exp_reg[3] = 16'h002a;
    exp_reg[4] = 16'h0015;
    exp_reg[5] = 16'h0035;
    exp_reg[6] = 16'h0059;
    exp_reg[7] = 16'h03a6;
    exp_reg[13] = 16'hffff;
    exp_flt = 64'h0;
  endtask : set_defaults

  // Stored value after a write; read-only and spare words keep theirs
  function automatic logic [15:0] wmask(input int i, input logic [31:0] d);
    case (i)
      3: return {9'h000, d[6:0]};
      4, 5, 6, 7: return {6'h00, d[9:0]};
      default: return exp_reg[i];
    endcase
  endfunction : wmask

  // Word the channel must carry for a marker kind
  function automatic ssc_code_t mword(input int k);
    case (k)
      0: return {3'b110, exp_reg[3][6:0]};
      1: return {3'b101, exp_reg[3][6:0]};
      2: return exp_reg[4][9:0];
      3: return exp_reg[5][9:0];
      default: return exp_reg[6][9:0];
    endcase
  endfunction : mword

  // ==========================================================
  // APB master: waits for pready, never assumes a latency
  task automatic apb(input logic w, input logic [5:0] i, input logic [1:0] lo, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic read_all();
    for (int i = 3; i <= 13; i++) begin
      if (i >= 8 && i <= 11) exp_reg[i] = exp_flt[(i-8)*16 +: 16];
      apb(1'b0, 6'(i), 2'b00, 32'h0);
      chk(rd, {16'h0000, exp_reg[i]});
    end
  endtask : read_all

  // Back-to-back markers; first five cover every kind, the rest random
  task automatic push(input int n, input int lim, output int acc);
    int idle, k;
    acc = 0;
    idle = 0;
    k = 0;
    @(posedge clk);
    mark_valid <= 1'b1;
    mark_kind <= ssc_kind_t'(k);
    while (acc < n && idle < lim) begin
      @(posedge clk);
      if (mark_ready === 1'b1) begin
        exp_q.push_back(mword(k));
        acc++;
        idle = 0;
        k = (acc < 5) ? acc : $unsigned($random(seed)) % 5;
        mark_kind <= ssc_kind_t'(k);
      end else idle++;
    end
    mark_valid <= 1'b0;
  endtask : push

  // Release the receiver and compare every marker word in order
  task automatic drain();
    @(posedge clk);
    stall <= 1'b0;
    @(posedge clk);
    for (int t = 0; t < 200 && rx_u.got.size() < exp_q.size(); t++) @(posedge clk);
    chk(32'(rx_u.got.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && rx_u.got.size() > 0) begin
      chk_code(rx_u.got.pop_front(), exp_q.pop_front());
    end
  endtask : drain

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    int acc;
    logic [31:0] wd;
    logic [63:0] fv;
    logic [7:0] bad [4];
    bad = '{8'h08, 8'h38, 8'h11, 8'h16};
    set_defaults();
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    read_all();
    chk_code(last_train, 10'h3a6);
    // Random writes everywhere, read-only and spare words included
    for (int i = 3; i <= 13; i++) begin
      wd = $random(seed);
      apb(1'b1, 6'(i), 2'b00, wd);
      exp_reg[i] = wmask(i, wd);
      chk({31'h0, er}, 32'h0);
    end
    // Byte lanes: low lane only into the dark tag, no lane into the frame bits
    pstrb <= 4'h1;
    apb(1'b1, 6'h04, 2'b00, 32'h0000_03c3);
    exp_reg[4][7:0] = 8'hc3;
    pstrb <= 4'h0;
    apb(1'b1, 6'h03, 2'b00, 32'h0000_007f);
    pstrb <= 4'hf;
    read_all();
    for (int t = 0; t < 20 && last_train !== exp_reg[7][9:0]; t++) @(posedge clk);
    chk_code(last_train, exp_reg[7][9:0]);
    // Markers while the receiver stalls at random
    fork
      push(24, 60, acc);
      repeat (80) begin
        @(posedge clk);
        stall <= 1'($random(seed));
      end
    join
    chk(32'(acc), 32'd24);
    drain();
    // Fill the queue until it refuses, then empty it
    stall <= 1'b1;
    push(14, 6, acc);
    chk({31'h0, mark_ready}, 32'h0);
    // Eight words in the array plus the head register
    chk(32'(acc), 32'd9);
    drain();
    chk({31'h0, mark_ready}, 32'h1);
    // Fault pulses, channels 0 and 63 at the edges
    fv = {$random(seed), $random(seed)};
    fault_set <= fv;
    @(posedge clk);
    fault_set <= 64'h8000_0000_0000_0001;
    @(posedge clk);
    fault_set <= 64'h0;
    exp_flt = fv | 64'h8000_0000_0000_0001;
    read_all();
    // Clear together with a set: the set survives
    fault_clear <= 1'b1;
    fault_set <= 64'h0001_0000_0000_0000;
    @(posedge clk);
    fault_clear <= 1'b0;
    fault_set <= 64'h0;
    exp_flt = 64'h0001_0000_0000_0000;
    read_all();
    // Unmapped and misaligned accesses are refused and change nothing
    for (int j = 0; j < 4; j++) begin
      apb(1'(j), bad[j][7:2], bad[j][1:0], 32'h3ff);
      chk({31'h0, er}, 32'h1);
      if (j % 2 == 0) chk(rd, 32'h0);
    end
    read_all();
    chk(32'(gaps), 32'h0);
    // Second reset in mid-run restores every register
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    set_defaults();
    read_all();
    chk_code(last_train, 10'h3a6);
    chk(32'(gaps), 32'h0);
    results();
  end
endmodule : testbench
